// ---- verilog/vcr_consts.svh ----
// offsets, field positions, reset values, select codes and the table entry count for the vc resource registers
`ifndef VCR_CONSTS_SVH
`define VCR_CONSTS_SVH
`define VCR_OFF_VC0_STATUS 12'h158
`define VCR_OFF_VC1_CAP 12'h15c
`define VCR_OFF_VC1_CTRL 12'h160
`define VCR_ST_TBL_BIT 16
`define VCR_ST_NEG_BIT 17
`define VCR_CAP_PARB_LSB 0
`define VCR_CAP_MTS_LSB 16
`define VCR_CAP_TBLOFS_LSB 24
`define VCR_CTL_TCMAP_LSB 0
`define VCR_CTL_LOAD_BIT 16
`define VCR_CTL_ASEL_LSB 17
`define VCR_CTL_VCID_LSB 24
`define VCR_CTL_EN_BIT 31
`define VCR_PARB_CNT0 8'h00
`define VCR_PARB_CNT1 8'h19
`define VCR_MTS_CNT0 7'h00
`define VCR_MTS_CNT1 7'h7f
`define VCR_TBLOFS_CNT0 8'h00
`define VCR_TBLOFS_CNT1 8'h08
`define VCR_VCID_CNT0 3'h0
`define VCR_VCID_CNT1 3'h1
`define VCR_TCMAP_RST 8'h00
`define VCR_ASEL_RR 3'h0
`define VCR_ASEL_WRR 3'h3
`define VCR_ASEL_TWRR 3'h4
`define VCR_TBL_ENTRIES 8'h80
`endif

// ---- verilog/vcr_pkg.sv ----
// types shared by the vc resource register block
package vcr_pkg;
  typedef enum logic [2:0] {
    VCR_ARB_RR = 3'h0,
    VCR_ARB_WRR128 = 3'h3,
    VCR_ARB_TWRR128 = 3'h4
  } vcr_arb_e;
  // configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } vcr_cfg_req_s;
  // externally loadable defaults (serial management or eeprom)
  typedef struct packed {
    logic load;
    logic [7:0] tc_map;
    logic [6:0] max_slots;
  } vcr_dflt_s;
  // settings handed to the vc1 arbiter
  typedef struct packed {
    logic vc_en;
    logic [2:0] vc_id;
    vcr_arb_e arb_sel;
    logic [7:0] tc_map;
  } vcr_vc1_cfg_s;
endpackage : vcr_pkg

// ---- verilog/vcr_tbl_loader.sv ----
// walks the port arbitration table when a load is requested
`timescale 1ns/1ns
`include "vcr_consts.svh"
module vcr_tbl_loader (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic [6:0] idx_o,
  output logic done_o
);
  typedef enum logic [1:0] {
    VCR_LD_IDLE = 2'b01,
    VCR_LD_RUN = 2'b10
  } vcr_ld_e;
  vcr_ld_e state_q;
  logic [7:0] cnt_q;

  // one entry per cycle; a start while busy is absorbed by the running pass
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= VCR_LD_IDLE;
      cnt_q <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        VCR_LD_IDLE: begin
          if (start_i) begin
            state_q <= VCR_LD_RUN;
            cnt_q <= 8'h00;
          end
        end
        VCR_LD_RUN: begin
          if (cnt_q == `VCR_TBL_ENTRIES - 8'h01) begin
            state_q <= VCR_LD_IDLE;
            done_o <= 1'b1;
          end
          cnt_q <= cnt_q + 8'h01;
        end
        default: state_q <= VCR_LD_IDLE;
      endcase
    end
  end

  assign busy_o = (state_q == VCR_LD_RUN);
  assign idx_o = cnt_q[6:0];
endmodule : vcr_tbl_loader

// ---- verilog/vcr_regs.sv ----
// vc0 status, vc1 capability and vc1 control configuration registers
`timescale 1ns/1ns
`include "vcr_consts.svh"
module vcr_regs (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire vcr_pkg::vcr_cfg_req_s cfg_req_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic [2:0] vc_count_i,
  input wire logic tbl_entry_wr_i,
  input wire logic vc_neg_busy_i,
  input wire vcr_pkg::vcr_dflt_s dflt_i,
  output vcr_pkg::vcr_vc1_cfg_s vc1_cfg_o,
  output logic tbl_load_busy_o,
  output logic [6:0] tbl_load_idx_o
);
  logic vc_cnt_one;
  logic hit_st;
  logic hit_cap;
  logic hit_ctl;
  logic wr_ctl;
  logic tbl_status_q;
  logic neg_pend_q;
  logic [7:0] parb_cap_q;
  logic [6:0] max_slots_q;
  logic [7:0] tbl_ofs_q;
  logic [7:1] tc_map_q;
  vcr_pkg::vcr_arb_e arb_sel_q;
  logic [2:0] vc_id_q;
  logic vc_en_q;
  logic load_pulse;
  logic load_done;
  logic [2:0] asel_wr;
  logic [31:0] st_word;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] rdata_d;

  // vc count field from 144h decides the vc1 defaults
  assign vc_cnt_one = (vc_count_i == 3'h1);

  // address decode; unmapped addresses read zero
  assign hit_st = (cfg_req_i.addr == `VCR_OFF_VC0_STATUS);
  assign hit_cap = (cfg_req_i.addr == `VCR_OFF_VC1_CAP);
  assign hit_ctl = (cfg_req_i.addr == `VCR_OFF_VC1_CTRL);
  assign wr_ctl = cfg_req_i.wr & hit_ctl;

  // load request is a write-only pulse, never stored
  assign load_pulse = wr_ctl & cfg_req_i.be[2] & cfg_req_i.wdata[`VCR_CTL_LOAD_BIT];

  vcr_tbl_loader u_loader (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(load_pulse),
    .busy_o(tbl_load_busy_o),
    .idx_o(tbl_load_idx_o),
    .done_o(load_done)
  );

  // table status: a write in the finishing cycle keeps the bit set
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tbl_status_q <= 1'b0;
    end else if (tbl_entry_wr_i) begin
      tbl_status_q <= 1'b1;
    end else if (load_done) begin
      tbl_status_q <= 1'b0;
    end
  end

  // negotiation pending mirrors the link negotiation state
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      neg_pend_q <= 1'b0;
    end else begin
      neg_pend_q <= vc_neg_busy_i;
    end
  end

  // capability defaults follow the vc count; max slots may be overridden
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      parb_cap_q <= `VCR_PARB_CNT0;
      max_slots_q <= `VCR_MTS_CNT0;
      tbl_ofs_q <= `VCR_TBLOFS_CNT0;
    end else begin
      // 19h advertises rr, wrr128 and time-based wrr128 on vc1
      parb_cap_q <= vc_cnt_one ? `VCR_PARB_CNT1 : `VCR_PARB_CNT0;
      tbl_ofs_q <= vc_cnt_one ? `VCR_TBLOFS_CNT1 : `VCR_TBLOFS_CNT0;
      if (dflt_i.load) begin
        max_slots_q <= dflt_i.max_slots;
      end else if (!vc_cnt_one) begin
        max_slots_q <= `VCR_MTS_CNT0;
      end else if (max_slots_q == `VCR_MTS_CNT0) begin
        max_slots_q <= `VCR_MTS_CNT1;
      end
    end
  end

  // tc map; bit 0 has no storage so class 0 never maps to vc1
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tc_map_q <= 7'h00;
    end else if (wr_ctl & cfg_req_i.be[0]) begin
      tc_map_q <= cfg_req_i.wdata[7:1];
    end else if (dflt_i.load) begin
      tc_map_q <= dflt_i.tc_map[7:1];
    end
  end

  // unsupported arbitration codes fall back to round robin
  assign asel_wr = cfg_req_i.wdata[`VCR_CTL_ASEL_LSB +: 3];

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arb_sel_q <= vcr_pkg::VCR_ARB_RR;
    end else if (wr_ctl & cfg_req_i.be[2]) begin
      case (asel_wr)
        `VCR_ASEL_WRR: arb_sel_q <= vcr_pkg::VCR_ARB_WRR128;
        `VCR_ASEL_TWRR: arb_sel_q <= vcr_pkg::VCR_ARB_TWRR128;
        default: arb_sel_q <= vcr_pkg::VCR_ARB_RR;
      endcase
    end
  end

  // vc id default tracks vc count until software writes it
  logic vc_id_wr_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vc_id_q <= `VCR_VCID_CNT0;
      vc_id_wr_q <= 1'b0;
    end else if (wr_ctl & cfg_req_i.be[3]) begin
      vc_id_q <= cfg_req_i.wdata[`VCR_CTL_VCID_LSB +: 3];
      vc_id_wr_q <= 1'b1;
    end else if (!vc_id_wr_q) begin
      vc_id_q <= vc_cnt_one ? `VCR_VCID_CNT1 : `VCR_VCID_CNT0;
    end
  end

  // channel enable
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vc_en_q <= 1'b0;
    end else if (wr_ctl & cfg_req_i.be[3]) begin
      vc_en_q <= cfg_req_i.wdata[`VCR_CTL_EN_BIT];
    end
  end

  // read words; reserved and write-only bits are zero
  always_comb begin
    st_word = 32'h0000_0000;
    st_word[`VCR_ST_TBL_BIT] = tbl_status_q;
    st_word[`VCR_ST_NEG_BIT] = neg_pend_q;
    cap_word = 32'h0000_0000;
    cap_word[`VCR_CAP_PARB_LSB +: 8] = parb_cap_q;
    cap_word[`VCR_CAP_MTS_LSB +: 7] = max_slots_q;
    cap_word[`VCR_CAP_TBLOFS_LSB +: 8] = tbl_ofs_q;
    ctl_word = 32'h0000_0000;
    ctl_word[7:1] = tc_map_q;
    ctl_word[`VCR_CTL_ASEL_LSB +: 3] = arb_sel_q;
    ctl_word[`VCR_CTL_VCID_LSB +: 3] = vc_id_q;
    ctl_word[`VCR_CTL_EN_BIT] = vc_en_q;
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_st) begin
      rdata_d = st_word;
    end else if (hit_cap) begin
      rdata_d = cap_word;
    end else if (hit_ctl) begin
      rdata_d = ctl_word; // load bit absent, reads zero
    end
  end

  // read data registered, valid one cycle after the read strobe
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_req_i.rd;
      if (cfg_req_i.rd) begin
        cfg_rdata_o <= rdata_d;
      end
    end
  end

  // settings for the vc1 arbiter
  always_comb begin
    vc1_cfg_o.vc_en = vc_en_q;
    vc1_cfg_o.vc_id = vc_id_q;
    vc1_cfg_o.arb_sel = arb_sel_q;
    vc1_cfg_o.tc_map = {tc_map_q, 1'b0};
  end
endmodule : vcr_regs

// ---- verif/vcr_regs_assertions.sv ----
// port checker for the vc resource register block
`timescale 1ns/1ns
module vcr_regs_assertions (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire vcr_pkg::vcr_cfg_req_s cfg_req_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire vcr_pkg::vcr_vc1_cfg_s vc1_cfg_o,
  input wire logic tbl_load_busy_o,
  input wire logic [6:0] tbl_load_idx_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // control write decode and expected field values
  wire ctl_w = cfg_req_i.wr && cfg_req_i.addr == 12'h160;
  wire [2:0] s_w = cfg_req_i.wdata[19:17];
  wire [2:0] sel_w = (s_w == 3'h3 || s_w == 3'h4) ? s_w : 3'h0;
  wire [6:0] tc_w = cfg_req_i.wdata[7:1];
  wire [3:0] en_w = {cfg_req_i.wdata[31], cfg_req_i.wdata[26:24]};
  wire ld_w = ctl_w && cfg_req_i.be[2] && cfg_req_i.wdata[16];
  property p_rvalid; cfg_rvalid_o == $past(cfg_req_i.rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer late");
  property p_tcw; ctl_w && cfg_req_i.be[0] |=> vc1_cfg_o.tc_map == {$past(tc_w), 1'b0}; endproperty
  a_tcw: assert property (p_tcw) else $error("tc map wrong");
  property p_sel; ctl_w && cfg_req_i.be[2] |=> vc1_cfg_o.arb_sel == $past(sel_w); endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_en; ctl_w && cfg_req_i.be[3] |=> {vc1_cfg_o.vc_en, vc1_cfg_o.vc_id} == $past(en_w);
  endproperty
  a_en: assert property (p_en) else $error("enable or id wrong");
  property p_load; ld_w && !tbl_load_busy_o |=> tbl_load_busy_o && tbl_load_idx_o == 7'h0;
  endproperty
  a_load: assert property (p_load) else $error("load not started");
  property p_idx;
    tbl_load_busy_o && $past(tbl_load_busy_o) |-> tbl_load_idx_o == $past(tbl_load_idx_o) + 7'h1;
  endproperty
  a_idx: assert property (p_idx) else $error("index skipped");
  property p_done; tbl_load_busy_o && tbl_load_idx_o == 7'h7f |=> !tbl_load_busy_o; endproperty
  a_done: assert property (p_done) else $error("load overran");
  property p_rsv; cfg_req_i.rd && cfg_req_i.addr == 12'h160 |=> (cfg_rdata_o & 32'h78f1ff01) == 0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("control reserved set");
  c_load: cover property (ld_w);
  // a whole table pass seen to its last entry and back to idle
  c_done: cover property (tbl_load_busy_o && tbl_load_idx_o == 7'h7f ##1 !tbl_load_busy_o);
  c_rd: cover property (cfg_rvalid_o);
endmodule : vcr_regs_assertions
bind vcr_regs vcr_regs_assertions u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
  .vc1_cfg_o(vc1_cfg_o), .tbl_load_busy_o(tbl_load_busy_o), .tbl_load_idx_o(tbl_load_idx_o));

// ---- verif/vcr_regs_tb.sv ----
// self-checking bench for the vc resource register block
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t mismatch", $time); end end
module vcr_regs_tb;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  vcr_pkg::vcr_cfg_req_s req = '0;
  vcr_pkg::vcr_dflt_s dflt = '0;
  vcr_pkg::vcr_vc1_cfg_s cfg;
  logic [2:0] vc_count = 3'h1;
  logic tbl_wr = 1'b0;
  logic neg_busy = 1'b0;
  logic [31:0] rdata;
  logic rvalid;
  logic busy;
  logic [31:0] seed = 32'hc7bf54e9;
  logic [31:0] v;
  logic [31:0] w;
  int num_errors = 0;
  int n_checks = 0;
  vcr_regs DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cfg_req_i(req),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .vc_count_i(vc_count), .tbl_entry_wr_i(tbl_wr),
    .vc_neg_busy_i(neg_busy), .dflt_i(dflt), .vc1_cfg_o(cfg), .tbl_load_busy_o(busy),
    .tbl_load_idx_o());
  // 100 ns period
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // readback: load and reserved bits drop, unknown selects fold to round robin
  function automatic logic [31:0] exp_ctl(input logic [31:0] d);
    logic [2:0] s;
    s = (d[19:17] == 3'h3 || d[19:17] == 3'h4) ? d[19:17] : 3'h0;
    return {d[31], 4'h0, d[26:24], 4'h0, s, 1'b0, 8'h00, d[7:1], 1'b0};
  endfunction : exp_ctl
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys_i);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    @(negedge clk_sys_i);
    req = '0;
  endtask : wr
  // answer stands one cycle, so it is taken at the next falling edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk_sys_i);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hf, wdata: 32'h0};
    @(negedge clk_sys_i);
    req = '0;
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask : rd
  task automatic do_reset(input logic [2:0] c);
    sys_rst_i = 1'b1;
    vc_count = c;
    repeat (8) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask : do_reset
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // the run needs about 280 cycles; far beyond that means a hang
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end
  initial begin
    for (int c = 0; c < 2; c++) begin
      do_reset(c[2:0]);
      rd(12'h15c, v);
      `CHK(v, c ? 32'h087f0019 : 32'h0)
      rd(12'h160, v);
      `CHK(v, c ? 32'h01000000 : 32'h0)
    end
    // read-only and unmapped places
    wr(12'h15c, 4'hf, 32'hffffffff);
    wr(12'h158, 4'hf, 32'hffffffff);
    rd(12'h15c, v);
    `CHK(v, 32'h087f0019)
    rd(12'h164, v);
    `CHK(v, 32'h0)
    // table write and negotiation, then a full table load
    @(negedge clk_sys_i);
    tbl_wr = 1'b1;
    neg_busy = 1'b1;
    @(negedge clk_sys_i);
    tbl_wr = 1'b0;
    rd(12'h158, v);
    `CHK(v, 32'h00030000)
    neg_busy = 1'b0;
    wr(12'h160, 4'h4, 32'h00010000);
    `CHK(busy, 1'b1)
    rd(12'h158, v);
    `CHK(v, 32'h00010000)
    repeat (130) @(negedge clk_sys_i);
    rd(12'h158, v);
    `CHK(v, 32'h0)
    // serial default load; bit 0 must not stick
    @(negedge clk_sys_i);
    dflt = '{load: 1'b1, tc_map: 8'hff, max_slots: 7'h2a};
    @(negedge clk_sys_i);
    dflt = '0;
    rd(12'h15c, v);
    `CHK(v[22:16], 7'h2a)
    `CHK(cfg.tc_map, 8'hfe)
    // random control words, every select code among the first eight
    for (int i = 0; i < 24; i++) begin
      w = rnd();
      if (i < 8) w[19:17] = i[2:0];
      wr(12'h160, 4'hf, w);
      rd(12'h160, v);
      `CHK(v, exp_ctl(w))
    end
    close_out();
  end
endmodule : vcr_regs_tb
